// *** shared/sim_pkg.sv ***
// package: register offsets, field positions and reset values
package sim_pkg;
	// ------------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_BUF_BASE   = 8'h64;
	localparam logic [7:0] OFS_COUNT      = 8'h68;
	localparam logic [7:0] OFS_MASK_SET   = 8'h70;
	localparam logic [7:0] OFS_MASK_CLEAR = 8'h74;
	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int BASE_LSB   = 11;
	localparam int FAULT_BIT  = 31;
	localparam int GEN_LSB    = 16;
	localparam int GEN_W      = 8;
	localparam int QCNT_LSB   = 2;
	localparam int QCNT_W     = 9;
	localparam int CHAN_FIRST = 32;
	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [20:0] BASE_RST = 21'h000000;
	localparam logic [7:0]  GEN_RST  = 8'h00;
	localparam logic [8:0]  QCNT_RST = 9'h000;
	localparam logic [31:0] MASK_RST = 32'h00000000;
endpackage : sim_pkg

// *** core/sim_regs.sv ***
// enumeration buffer, count status and upper channel mask registers
`timescale 1ns/100ps
// Operation
// - base pointer bits 31..11 read/write
// - base pointer low eleven bits read zero
// - packets stored from 2K-aligned base
// - any reception error sets fault flag
// - clean reception finish clears fault flag
// - hardware fault or write failure are errors
// - generation increments on each bus reset
// - generation wraps to zero after 255
// - quadlet count tracks written quadlets
// - quadlet count zeroed at reception start
// - count reserved bits read zero
// - upper mask gates isochronous reception
// - mask bit n enables channel 32+n
// - set and clear addresses read mask
// - bit 0 enables channel 32
module sim_regs (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	// receive logic events
	input  wire logic        bus_reset_seen,
	input  wire logic        enum_rx_start,
	input  wire logic        enum_quadlet_written,
	input  wire logic        enum_rx_done,
	input  wire logic        enum_hw_fault,
	input  wire logic        enum_host_write_fail,
	// buffer addressing for the receive dma
	output logic      [31:0] enum_write_addr,
	// isochronous channel filter
	input  wire logic [5:0]  iso_channel,
	output logic             iso_channel_accept
);
	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [20:0] base_hi;
	logic [20:0] next_base_hi;
	logic        enumeration_fault_flag;
	logic        next_enumeration_fault_flag;
	logic        rx_err_seen;
	logic        next_rx_err_seen;
	logic [7:0]  bus_reset_generation;
	logic [7:0]  next_bus_reset_generation;
	logic [8:0]  enumeration_quadlet_count;
	logic [8:0]  next_enumeration_quadlet_count;
	logic [31:0] upper_channel_rx_enable;
	logic [31:0] next_upper_channel_rx_enable;
	logic [31:0] next_reg_rdata;
	logic        rx_error;
	logic [31:0] next_enum_write_addr;
	logic        next_iso_channel_accept;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	// errors of either kind count against the reception
	assign rx_error = enum_hw_fault | enum_host_write_fail;

	// ------------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		next_base_hi = base_hi;
		next_enumeration_fault_flag = enumeration_fault_flag;
		next_rx_err_seen = rx_err_seen;
		next_bus_reset_generation = bus_reset_generation;
		next_enumeration_quadlet_count = enumeration_quadlet_count;
		next_upper_channel_rx_enable = upper_channel_rx_enable;
		// only the upper pointer bits are writable
		if (reg_wr && hit(reg_addr, sim_pkg::OFS_BUF_BASE)) begin
			next_base_hi = reg_wdata[31:sim_pkg::BASE_LSB];
		end else if (reg_wr && hit(reg_addr, sim_pkg::OFS_MASK_SET)) begin
			next_upper_channel_rx_enable =
				upper_channel_rx_enable | reg_wdata;
		end else if (reg_wr && hit(reg_addr, sim_pkg::OFS_MASK_CLEAR)) begin
			next_upper_channel_rx_enable =
				upper_channel_rx_enable & ~reg_wdata;
		end
		// generation counter wraps naturally at eight bits
		if (bus_reset_seen) begin
			next_bus_reset_generation =
				bus_reset_generation + 8'h01;
		end
		// quadlet count: start clears, each write adds one
		if (enum_rx_start) begin
			next_enumeration_quadlet_count = sim_pkg::QCNT_RST;
			next_rx_err_seen = rx_error;
		end else begin
			if (enum_quadlet_written) begin
				next_enumeration_quadlet_count =
					enumeration_quadlet_count + 9'h001;
			end
			if (rx_error) begin
				next_rx_err_seen = 1'b1;
			end
		end
		// fault flag: set at once on error, cleared on a clean finish
		if (rx_error) begin
			next_enumeration_fault_flag = 1'b1;
		end else if (enum_rx_done && !rx_err_seen) begin
			next_enumeration_fault_flag = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// read data path
	// ------------------------------------------------------------------
	always_comb begin
		next_reg_rdata = 32'h00000000;
		if (reg_rd && hit(reg_addr, sim_pkg::OFS_BUF_BASE)) begin
			next_reg_rdata = {base_hi, 11'h000};
		end else if (reg_rd && hit(reg_addr, sim_pkg::OFS_COUNT)) begin
			next_reg_rdata = {enumeration_fault_flag, 7'h00,
				bus_reset_generation, 5'h00,
				enumeration_quadlet_count, 2'h0};
		end else if (reg_rd && (hit(reg_addr, sim_pkg::OFS_MASK_SET) ||
			hit(reg_addr, sim_pkg::OFS_MASK_CLEAR))) begin
			next_reg_rdata = upper_channel_rx_enable;
		end
	end

	// ------------------------------------------------------------------
	// buffer address and channel filter
	// ------------------------------------------------------------------
	// the address follows the count as it stands after this edge, so the
	// first quadlet of a reception lands on the aligned base itself
	always_comb begin
		next_enum_write_addr = {base_hi, 11'h000} +
			{21'h000000, next_enumeration_quadlet_count, 2'h0};
		// channels 32..63 only; bit n gates channel 32+n, bit 0 channel 32
		next_iso_channel_accept = iso_channel[5] &
			upper_channel_rx_enable[iso_channel[4:0]];
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			base_hi <= sim_pkg::BASE_RST;
			enumeration_fault_flag <= 1'b0;
			rx_err_seen <= 1'b0;
			bus_reset_generation <= sim_pkg::GEN_RST;
			enumeration_quadlet_count <= sim_pkg::QCNT_RST;
			upper_channel_rx_enable <= sim_pkg::MASK_RST;
			reg_rdata <= 32'h00000000;
			enum_write_addr <= 32'h00000000;
			iso_channel_accept <= 1'b0;
		end else begin
			base_hi <= next_base_hi;
			enumeration_fault_flag <= next_enumeration_fault_flag;
			rx_err_seen <= next_rx_err_seen;
			bus_reset_generation <= next_bus_reset_generation;
			enumeration_quadlet_count <= next_enumeration_quadlet_count;
			upper_channel_rx_enable <= next_upper_channel_rx_enable;
			reg_rdata <= next_reg_rdata;
			enum_write_addr <= next_enum_write_addr;
			iso_channel_accept <= next_iso_channel_accept;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	property p_base_rw;
		@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && reg_addr == sim_pkg::OFS_BUF_BASE
			|=> base_hi == $past(reg_wdata[31:11]);
	endproperty
	a_base_rw: assert property (p_base_rw)
		else $error("base pointer write lost");

	property p_base_low;
		@(posedge clk_sys) disable iff (!rst_n)
		$past(reg_rd) && $past(reg_addr) == sim_pkg::OFS_BUF_BASE
			|-> reg_rdata[10:0] == 11'h000;
	endproperty
	a_base_low: assert property (p_base_low)
		else $error("base pointer low bits not zero");

	property p_fault_set;
		@(posedge clk_sys) disable iff (!rst_n)
		rx_error |=> enumeration_fault_flag;
	endproperty
	a_fault_set: assert property (p_fault_set)
		else $error("fault flag not set on error");

	property p_fault_rise;
		@(posedge clk_sys) disable iff (!rst_n)
		!rx_error |=> !$rose(enumeration_fault_flag);
	endproperty
	a_fault_rise: assert property (p_fault_rise)
		else $error("fault flag set without an error");

	property p_fault_clr;
		@(posedge clk_sys) disable iff (!rst_n)
		enum_rx_done && !rx_error && !rx_err_seen
			|=> !enumeration_fault_flag;
	endproperty
	a_fault_clr: assert property (p_fault_clr)
		else $error("fault flag not cleared on clean reception");

	// a failed host write, then the finish of that same reception
	sequence s_write_fail;
		enum_host_write_fail && !enum_rx_done;
	endsequence
	sequence s_done_no_restart;
		!enum_rx_start ##1 enum_rx_done;
	endsequence
	property p_write_fail;
		@(posedge clk_sys) disable iff (!rst_n)
		s_write_fail ##1 s_done_no_restart |=> enumeration_fault_flag;
	endproperty
	a_write_fail: assert property (p_write_fail)
		else $error("host write failure not flagged");

	property p_gen_inc;
		@(posedge clk_sys) disable iff (!rst_n)
		bus_reset_seen |=>
			bus_reset_generation == $past(bus_reset_generation) + 8'h01;
	endproperty
	a_gen_inc: assert property (p_gen_inc)
		else $error("generation not incremented");

	property p_gen_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		!bus_reset_seen |=> $stable(bus_reset_generation);
	endproperty
	a_gen_hold: assert property (p_gen_hold)
		else $error("generation changed without bus reset");

	sequence s_rx_start;
		enum_rx_start;
	endsequence
	property p_qcnt_zero;
		@(posedge clk_sys) disable iff (!rst_n)
		s_rx_start |=> enumeration_quadlet_count == 9'h000;
	endproperty
	a_qcnt_zero: assert property (p_qcnt_zero)
		else $error("quadlet count not cleared at start");

	property p_start_addr;
		@(posedge clk_sys) disable iff (!rst_n)
		s_rx_start |=> enum_write_addr == {$past(base_hi), 11'h000};
	endproperty
	a_start_addr: assert property (p_start_addr)
		else $error("buffer address not at base after start");

	property p_qcnt_inc;
		@(posedge clk_sys) disable iff (!rst_n)
		enum_quadlet_written && !enum_rx_start |=> enumeration_quadlet_count
			== $past(enumeration_quadlet_count) + 9'h001;
	endproperty
	a_qcnt_inc: assert property (p_qcnt_inc)
		else $error("quadlet count not incremented");

	property p_qcnt_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		!enum_quadlet_written && !enum_rx_start
			|=> $stable(enumeration_quadlet_count);
	endproperty
	a_qcnt_hold: assert property (p_qcnt_hold)
		else $error("quadlet count changed without a quadlet");

	property p_count_rsvd;
		@(posedge clk_sys) disable iff (!rst_n)
		$past(reg_rd) && $past(reg_addr) == sim_pkg::OFS_COUNT |->
			reg_rdata[30:24] == 7'h00 && reg_rdata[15:11] == 5'h00 &&
			reg_rdata[1:0] == 2'h0;
	endproperty
	a_count_rsvd: assert property (p_count_rsvd)
		else $error("count reserved bits not zero");

	property p_mask_read;
		@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && (reg_addr == sim_pkg::OFS_MASK_SET ||
			reg_addr == sim_pkg::OFS_MASK_CLEAR)
			|=> reg_rdata == $past(upper_channel_rx_enable);
	endproperty
	a_mask_read: assert property (p_mask_read)
		else $error("mask read mismatch");

	property p_mask_set;
		@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && reg_addr == sim_pkg::OFS_MASK_SET |=>
			upper_channel_rx_enable == ($past(upper_channel_rx_enable)
			| $past(reg_wdata));
	endproperty
	a_mask_set: assert property (p_mask_set)
		else $error("mask set write wrong");

	property p_mask_clr;
		@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && reg_addr == sim_pkg::OFS_MASK_CLEAR |=>
			upper_channel_rx_enable == ($past(upper_channel_rx_enable)
			& ~$past(reg_wdata));
	endproperty
	a_mask_clr: assert property (p_mask_clr)
		else $error("mask clear write wrong");

	property p_accept;
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> iso_channel_accept == ($past(iso_channel[5]) &&
			$past(upper_channel_rx_enable[iso_channel[4:0]]));
	endproperty
	a_accept: assert property (p_accept)
		else $error("channel filter wrong");
endmodule : sim_regs

// *** verification/sim_rx_model.sv ***
// partner model: receive logic that raises enumeration events
`timescale 1ns/100ps
module sim_rx_model (
	input  wire logic clk_sys,
	output logic      bus_reset_seen,
	output logic      enum_rx_start,
	output logic      enum_quadlet_written,
	output logic      enum_rx_done,
	output logic      enum_hw_fault,
	output logic      enum_host_write_fail
);
	// one vector of strobes, idle from time zero
	logic [5:0] ev = 6'h00;
	assign {bus_reset_seen, enum_rx_start, enum_quadlet_written} = ev[5:3];
	assign {enum_rx_done, enum_hw_fault, enum_host_write_fail} = ev[2:0];
	// one-cycle strobe, then an idle cycle
	task pulse(input logic [5:0] v);
		ev <= v;
		@(posedge clk_sys);
		ev <= 6'h00;
		@(posedge clk_sys);
	endtask : pulse
	// start, quadlets, optional error, done
	task packet(input int n, input logic [5:0] err);
		pulse(6'h10);
		repeat (n) pulse(6'h08);
		if (err != 6'h00) pulse(err);
		pulse(6'h04);
	endtask : packet
endmodule : sim_rx_model

// *** verification/tb.sv ***
// testbench: register bank driven against the receive model
`timescale 1ns/100ps
module tb;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_wdata = 32'h00000000;
	logic [31:0] reg_rdata;
	logic        bus_reset_seen, enum_rx_start, enum_quadlet_written;
	logic        enum_rx_done, enum_hw_fault, enum_host_write_fail;
	logic [31:0] enum_write_addr;
	logic [5:0]  iso_channel = 6'h00;
	logic        iso_channel_accept;
	logic        iso_chk = 1'b0, rd_pend = 1'b0, iso_pend = 1'b0;
	logic [31:0] rd_q[$];
	logic        acc_q[$];
	logic [31:0] seed = 32'h00012B56;
	logic [31:0] base, mask, m;
	int          miscompares = 0, compares = 0;

	always #5 clk_sys = ~clk_sys;

	sim_regs u_sim_regs (.clk_sys(clk_sys), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.bus_reset_seen(bus_reset_seen), .enum_rx_start(enum_rx_start),
		.enum_quadlet_written(enum_quadlet_written),
		.enum_rx_done(enum_rx_done), .enum_hw_fault(enum_hw_fault),
		.enum_host_write_fail(enum_host_write_fail),
		.enum_write_addr(enum_write_addr), .iso_channel(iso_channel),
		.iso_channel_accept(iso_channel_accept));
	sim_rx_model u_sim_rx_model (.clk_sys(clk_sys),
		.bus_reset_seen(bus_reset_seen), .enum_rx_start(enum_rx_start),
		.enum_quadlet_written(enum_quadlet_written),
		.enum_rx_done(enum_rx_done), .enum_hw_fault(enum_hw_fault),
		.enum_host_write_fail(enum_host_write_fail));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xorshift
	function automatic logic [31:0] cnt(logic f, logic [7:0] g, logic [8:0] q);
		return {f, 7'h00, g, 5'h00, q, 2'h0};
	endfunction : cnt
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] exp);
		rd_q.push_back(exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
	endtask : rd
	task acc(input logic [5:0] ch, input logic exp);
		acc_q.push_back(exp);
		iso_channel <= ch;
		iso_chk <= 1'b1;
		@(posedge clk_sys);
		iso_chk <= 1'b0;
		@(posedge clk_sys);
	endtask : acc
	task complete_run();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	// watcher: results a cycle after their request, oldest note first
	always @(posedge clk_sys) begin
		if (rd_pend) check(reg_rdata, rd_q.pop_front());
		if (iso_pend) begin
			check({31'h0, iso_channel_accept},
				{31'h0, acc_q.pop_front()});
		end
		rd_pend <= reg_rd;
		iso_pend <= iso_chk;
	end

	// ------------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd(sim_pkg::OFS_BUF_BASE, 32'h00000000);
		rd(8'h60, 32'h00000000);
		base = xorshift();
		wr(sim_pkg::OFS_BUF_BASE, base);
		base = base & 32'hFFFFF800;
		rd(sim_pkg::OFS_BUF_BASE, base);
		wr(sim_pkg::OFS_COUNT, 32'hFFFFFFFF);
		rd(sim_pkg::OFS_COUNT, 32'h00000000);
		$display("test base done");
		// 257 resets: generation wraps through zero to one
		repeat (257) u_sim_rx_model.pulse(6'h20);
		u_sim_rx_model.packet(3, 6'h00);
		rd(sim_pkg::OFS_COUNT, cnt(1'b0, 8'h01, 9'h003));
		check(enum_write_addr, base + 32'h0000000C);
		u_sim_rx_model.packet(2, 6'h02);
		rd(sim_pkg::OFS_COUNT, cnt(1'b1, 8'h01, 9'h002));
		u_sim_rx_model.packet(1, 6'h00);
		rd(sim_pkg::OFS_COUNT, cnt(1'b0, 8'h01, 9'h001));
		u_sim_rx_model.pulse(6'h01);
		rd(sim_pkg::OFS_COUNT, cnt(1'b1, 8'h01, 9'h001));
		u_sim_rx_model.pulse(6'h20);
		u_sim_rx_model.packet(0, 6'h00);
		rd(sim_pkg::OFS_COUNT, cnt(1'b0, 8'h02, 9'h000));
		// host write failure inside a reception keeps the flag past done
		u_sim_rx_model.packet(4, 6'h01);
		rd(sim_pkg::OFS_COUNT, cnt(1'b1, 8'h02, 9'h004));
		check(enum_write_addr, base + 32'h00000010);
		$display("test count done");
		mask = xorshift();
		wr(sim_pkg::OFS_MASK_SET, mask);
		m = xorshift();
		wr(sim_pkg::OFS_MASK_CLEAR, m);
		mask = mask & ~m;
		rd(sim_pkg::OFS_MASK_SET, mask);
		rd(sim_pkg::OFS_MASK_CLEAR, mask);
		m = xorshift() | 32'h00000001;
		wr(sim_pkg::OFS_MASK_SET, m);
		mask = mask | m;
		for (int ch = 0; ch < 64; ch++) begin
			acc(6'(ch), ch >= sim_pkg::CHAN_FIRST &&
				mask[ch % sim_pkg::CHAN_FIRST]);
		end
		$display("test mask done");
		complete_run();
	end

	// watchdog against a hang
	initial begin
		#100000;
		miscompares++;
		complete_run();
	end
endmodule : tb
